// >>> verilog/mtsr_router.sv
/*
  Trigger routing matrix: trigger-bus lines, star trigger, axis trigger
  inputs, breakpoints and soft trigger port to capture inputs and lines.
  Assumes pins are asynchronous; selections come from logic on i_ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mtsr_regs.svh"

module mtsr_router (
  input wire logic i_ref_clk, // Reference clock, 50 MHz.
  input wire logic i_rst, // Synchronous reset, active high.
  input wire logic [7:0] i_trigger_bus_line, // Bus line pin levels.
  output logic [7:0] o_trigger_bus_line, // Bus line drive values.
  output logic [7:0] o_trigger_bus_line_oe_n, // Low while driving.
  input wire logic i_star_trig, // Star trigger pin level.
  output logic o_star_trig, // Star trigger drive value.
  output logic o_star_trig_oe_n, // Low while driving.
  input wire logic [7:0] i_axis_trig, // Axis trigger input pins.
  input wire logic [7:0] i_bp_event, // One-cycle breakpoint events.
  input wire logic i_cfg_we, // Routing write strobe.
  input wire logic i_cfg_is_cap, // 1 capture destination, 0 line.
  input wire logic [3:0] i_cfg_dest, // Destination index, 8 star on lines.
  input wire logic [3:0] i_cfg_src, // Source code.
  input wire logic [7:0] i_cap_pol, // Capture active edge, 1 rising.
  input wire logic i_must_on_must_off_write_we, // Must-on/must-off write strobe.
  input wire logic [7:0] i_must_on, // Bits to set.
  input wire logic [7:0] i_must_off, // Bits to clear; must-on wins.
  input wire logic [7:0] i_port_pol, // Latch active level, 1 high.
  input wire logic i_port_rd, // Port read strobe; restarts latch from current activity.
  output logic [7:0] o_port_rd_data, // Latched activity at read.
  output logic [7:0] o_line_state, // Current line levels.
  output logic [7:0] o_cap_strobe // Capture events on active edge.
);
  logic [2:0][7:0] bus_sync_q;
  logic [2:0][7:0] axis_sync_q;
  logic [2:0] star_sync_q;
  logic [7:0] bus_lvl_q;
  logic [7:0] bus_lvl_d;
  logic [7:0] axis_lvl_q;
  logic [7:0] axis_lvl_d;
  logic star_lvl_q;
  logic star_lvl_d;
  logic [7:0] line_en_q;
  logic [7:0] line_en_d;
  logic star_en_q;
  logic star_en_d;
  mtsr_pkg::mtsr_sel_t line_src_q [8];
  mtsr_pkg::mtsr_sel_t line_src_d [8];
  mtsr_pkg::mtsr_sel_t star_src_q;
  mtsr_pkg::mtsr_sel_t star_src_d;
  mtsr_pkg::mtsr_sel_t cap_src_q [8];
  mtsr_pkg::mtsr_sel_t cap_src_d [8];
  logic [7:0] soft_q;
  logic [7:0] soft_d;
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic [7:0] cap_in_q;
  logic [7:0] cap_in_d;
  logic [7:0] cap_stb_d;
  logic [7:0] cap_stb_q;
  logic [7:0] out_d;
  logic [7:0] out_q;
  logic star_out_d;
  logic star_out_q;
  logic [7:0] bp_pulse;
  logic [7:0] active;

  // Three-stage synchronisers; a change counts once stages two and three agree.
  always_comb
  begin
    bus_lvl_d = bus_lvl_q;
    axis_lvl_d = axis_lvl_q;
    star_lvl_d = star_lvl_q;
    for (int i = 0; i < 8; i++)
    begin
      if (bus_sync_q[1][i] == bus_sync_q[2][i])
        bus_lvl_d[i] = bus_sync_q[2][i];
      if (axis_sync_q[1][i] == axis_sync_q[2][i])
        axis_lvl_d[i] = axis_sync_q[2][i];
    end
    if (star_sync_q[1] == star_sync_q[2])
      star_lvl_d = star_sync_q[2];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      bus_sync_q <= '0;
      axis_sync_q <= '0;
      star_sync_q <= 3'h0;
      bus_lvl_q <= 8'h00;
      axis_lvl_q <= 8'h00;
      star_lvl_q <= 1'b0;
    end
    else
    begin
      bus_sync_q <= {bus_sync_q[1:0], i_trigger_bus_line};
      axis_sync_q <= {axis_sync_q[1:0], i_axis_trig};
      star_sync_q <= {star_sync_q[1:0], i_star_trig};
      bus_lvl_q <= bus_lvl_d;
      axis_lvl_q <= axis_lvl_d;
      star_lvl_q <= star_lvl_d;
    end
  end

  // Breakpoint pulses are generated here, independent of the connector pin action.
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_bp
      mtsr_pulse_gen u_pulse (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_event(i_bp_event[g]),
        .o_pulse(bp_pulse[g])
      );
    end
  endgenerate

  // Routing selection. A line chosen as capture source is released from driving.
  always_comb
  begin
    line_en_d = line_en_q;
    star_en_d = star_en_q;
    line_src_d = line_src_q;
    star_src_d = star_src_q;
    cap_src_d = cap_src_q;
    if (i_cfg_we)
    begin
      if (i_cfg_is_cap)
      begin
        if (i_cfg_dest < 4'h8 && i_cfg_src <= `MTSR_CAP_SRC_TRIG)
        begin
          cap_src_d[i_cfg_dest[2:0]] = i_cfg_src;
          if (i_cfg_src < 4'h8)
            line_en_d[i_cfg_src[2:0]] = 1'b0;
        end
      end
      else if (i_cfg_src <= `MTSR_LINE_SRC_SOFT)
      begin
        if (i_cfg_dest < 4'h8)
        begin
          line_src_d[i_cfg_dest[2:0]] = i_cfg_src;
          line_en_d[i_cfg_dest[2:0]] = 1'b1;
        end
        else if (i_cfg_dest == 4'h8)
        begin
          star_src_d = i_cfg_src;
          star_en_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      line_en_q <= `MTSR_RST_LINE_EN;
      star_en_q <= 1'b0;
      star_src_q <= `MTSR_LINE_SRC_SOFT;
      for (int i = 0; i < 8; i++)
      begin
        line_src_q[i] <= `MTSR_LINE_SRC_SOFT;
        cap_src_q[i] <= `MTSR_RST_CAP_SRC;
      end
    end
    else
    begin
      line_en_q <= line_en_d;
      star_en_q <= star_en_d;
      line_src_q <= line_src_d;
      star_src_q <= star_src_d;
      cap_src_q <= cap_src_d;
    end
  end

  // Soft port, line drive, latch and capture.
  always_comb
  begin
    soft_d = soft_q;
    if (i_must_on_must_off_write_we)
      soft_d = (soft_q & ~i_must_off) | i_must_on;
    for (int i = 0; i < 8; i++)
    begin
      out_d[i] = (line_src_q[i] == `MTSR_LINE_SRC_SOFT) ? soft_q[i]
                 : bp_pulse[line_src_q[i][2:0]];
      case (cap_src_q[i])
        `MTSR_CAP_SRC_STAR: cap_in_d[i] = star_lvl_q;
        `MTSR_CAP_SRC_TRIG: cap_in_d[i] = axis_lvl_q[i];
        default: cap_in_d[i] = bus_lvl_q[cap_src_q[i][2:0]];
      endcase
    end
    star_out_d = (star_src_q == `MTSR_LINE_SRC_SOFT) ? 1'b0 : bp_pulse[star_src_q[2:0]];
    cap_stb_d = i_cap_pol & cap_in_d & ~cap_in_q | ~i_cap_pol & ~cap_in_d & cap_in_q;
    active = ~(bus_lvl_q ^ i_port_pol);
    rd_d = rd_q;
    latch_d = latch_q | active;
    if (i_port_rd)
    begin
      rd_d = latch_q | active;
      latch_d = active;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      soft_q <= 8'h00;
      out_q <= 8'h00;
      star_out_q <= 1'b0;
      cap_in_q <= 8'h00;
      cap_stb_q <= 8'h00;
      latch_q <= 8'h00;
      rd_q <= 8'h00;
    end
    else
    begin
      soft_q <= soft_d;
      out_q <= out_d;
      star_out_q <= star_out_d;
      cap_in_q <= cap_in_d;
      cap_stb_q <= cap_stb_d;
      latch_q <= latch_d;
      rd_q <= rd_d;
    end
  end

  assign o_trigger_bus_line = out_q;
  assign o_trigger_bus_line_oe_n = ~line_en_q;
  assign o_star_trig = star_out_q;
  assign o_star_trig_oe_n = ~star_en_q;
  assign o_cap_strobe = cap_stb_q;
  assign o_port_rd_data = rd_q;
  assign o_line_state = bus_lvl_q;

  property p_reset_undriven;
    @(posedge i_ref_clk) i_rst |=> o_trigger_bus_line_oe_n == 8'hff;
  endproperty
  a_reset_undriven: assert property (p_reset_undriven) else $error("line driven after reset");

  property p_soft_drive;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_must_on_must_off_write_we && i_must_on[2] && line_src_q[2] == `MTSR_LINE_SRC_SOFT
      ##1 line_src_q[2] == `MTSR_LINE_SRC_SOFT |=> o_trigger_bus_line[2];
  endproperty
  a_soft_drive: assert property (p_soft_drive) else $error("soft bit not driven");

  property p_cap_release;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_cfg_we && i_cfg_is_cap && i_cfg_dest < 4'h8 && i_cfg_src == 4'h3
      |=> o_trigger_bus_line_oe_n[3];
  endproperty
  a_cap_release: assert property (p_cap_release) else $error("capture source still driven");

  property p_dest_drive;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_cfg_we && !i_cfg_is_cap && i_cfg_dest == 4'h2 && i_cfg_src <= 4'h8
      |=> !o_trigger_bus_line_oe_n[2];
  endproperty
  a_dest_drive: assert property (p_dest_drive) else $error("destination line not driven");

  property p_latch_clear;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_port_rd && !active[6] && $past(!active[6]) |=> !latch_q[6];
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared by read");

  property p_cap_pol;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_cap_strobe[0] |-> $past(i_cap_pol[0]) == $past(cap_in_d[0]);
  endproperty
  a_cap_pol: assert property (p_cap_pol) else $error("capture edge polarity wrong");

  property p_cap_src;
    @(posedge i_ref_clk) disable iff (i_rst) cap_src_q[0] <= `MTSR_CAP_SRC_TRIG;
  endproperty
  a_cap_src: assert property (p_cap_src) else $error("illegal capture source");
endmodule : mtsr_router

`default_nettype wire

// >>> common/mtsr_regs.svh
/*
  Constants of the motion trigger signal router: source codes, line and axis
  counts, pulse timing and reset values.
  Assumes a 50 MHz reference clock; included by bare name.
*/
`ifndef MTSR_REGS_SVH
`define MTSR_REGS_SVH

`define MTSR_NUM_LINES 8
`define MTSR_NUM_AXES 8
`define MTSR_CLK_PERIOD_NS 20
`define MTSR_PULSE_MIN_NS 120
`define MTSR_PULSE_MAX_NS 150
// Least time rounds up: 120 ns / 20 ns = 6 cycles, inside the 150 ns ceiling.
`define MTSR_PULSE_CYC ((`MTSR_PULSE_MIN_NS + `MTSR_CLK_PERIOD_NS - 1) / `MTSR_CLK_PERIOD_NS)
// Capture source codes: 0..7 trigger-bus line, 8 star trigger, 9 own axis trigger input.
`define MTSR_CAP_SRC_STAR 4'h8
`define MTSR_CAP_SRC_TRIG 4'h9
// Line source codes: 0..7 breakpoint of axis n, 8 soft trigger port bit on lines 0..7, constant low on the star.
`define MTSR_LINE_SRC_SOFT 4'h8
`define MTSR_RST_LINE_EN 8'h00
`define MTSR_RST_CAP_SRC 4'h9

`endif

// >>> common/mtsr_pkg.sv
/*
  Types of the motion trigger signal router.
  Assumes nothing beyond the constants header.
*/
package mtsr_pkg;
  typedef logic [3:0] mtsr_sel_t;
  typedef enum logic [1:0] {MTSR_IDLE, MTSR_PULSE} mtsr_pulse_e;
endpackage : mtsr_pkg

// >>> verilog/mtsr_pulse_gen.sv
/*
  Stretches a one-cycle breakpoint event into a fixed high pulse.
  Assumes the event is a single-cycle strobe on the reference clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mtsr_regs.svh"

module mtsr_pulse_gen (
  input wire logic i_ref_clk, // Reference clock.
  input wire logic i_rst, // Synchronous reset, active high.
  input wire logic i_event, // One-cycle breakpoint event.
  output logic o_pulse // Stretched pulse.
);
  mtsr_pkg::mtsr_pulse_e state_q;
  mtsr_pkg::mtsr_pulse_e state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // An event during a pulse is merged, so each pulse keeps its full width.
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      mtsr_pkg::MTSR_IDLE:
      begin
        if (i_event)
        begin
          state_d = mtsr_pkg::MTSR_PULSE;
          cnt_d = 4'(`MTSR_PULSE_CYC - 1);
        end
      end
      mtsr_pkg::MTSR_PULSE:
      begin
        if (cnt_q == 4'h0)
          state_d = mtsr_pkg::MTSR_IDLE;
        else
          cnt_d = cnt_q - 4'h1;
      end
      default: state_d = mtsr_pkg::MTSR_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state_q <= mtsr_pkg::MTSR_IDLE;
      cnt_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_pulse = (state_q == mtsr_pkg::MTSR_PULSE);

  // Checked per instance, so every axis is covered, not only the first.
  sequence s_bp_pulse;
    o_pulse [*6] ##1 !o_pulse;
  endsequence
  property p_bp_width;
    @(posedge i_ref_clk) disable iff (i_rst) $rose(o_pulse) |-> s_bp_pulse;
  endproperty
  a_bp_width: assert property (p_bp_width) else $error("breakpoint pulse width wrong");
endmodule : mtsr_pulse_gen

`default_nettype wire

// >>> verification/mtsr_bus_partner.sv
/*
  Behavioural instruments that share the trigger bus lines with the router.
  Assumes the bench commands when an instrument drives; this model forms each pin level.
*/
`timescale 1ns/100ps
`default_nettype none

module mtsr_bus_partner (
  input wire logic i_ref_clk, // Reference clock.
  input wire logic [7:0] i_dut_val, // Router drive values.
  input wire logic [7:0] i_dut_oe_n, // Router drives while low.
  input wire logic [7:0] i_drv_en, // Instrument drives the line.
  input wire logic [7:0] i_drv_val, // Instrument drive values.
  output logic [7:0] o_line // Resolved pin levels.
);
  logic [7:0] float_q = 8'h00;

  // A line nobody drives has no pull, so it shows a changing pattern, not a held level.
  always_ff @(posedge i_ref_clk)
  begin
    float_q <= ~o_line;
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      o_line[i] = !i_dut_oe_n[i] ? i_dut_val[i] : (i_drv_en[i] ? i_drv_val[i] : float_q[i]);
    end
  end
endmodule : mtsr_bus_partner

`default_nettype wire

// >>> verification/mtsr_router_bench.sv
/*
  Self-checking bench of the trigger router with instruments on the bus lines.
  Assumes a 50 MHz clock and inputs driven 2 ns after the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mtsr_regs.svh"

module mtsr_router_bench;
  logic clk = 0, rst = 1, star = 0, cfg_we = 0, is_cap = 0, must_on_must_off_write_we = 0, rd = 0;
  logic [3:0] dest = 0, src = 0;
  logic [7:0] axis = 0, ev = 0, cap_pol = 8'hff, on = 0, off = 0, ppol = 8'h40;
  logic [7:0] drv_val = 0, line, out, oe_n, rd_data, state, cap;
  logic star_out, star_oe_n;
  int err_total = 0, checked = 0, sh = 0, lh[8], lr[8], ch[8];

  mtsr_bus_partner partner (.i_ref_clk(clk), .i_dut_val(out), .i_dut_oe_n(oe_n),
    .i_drv_en(8'hff), .i_drv_val(drv_val), .o_line(line));

  mtsr_router dut (.i_ref_clk(clk), .i_rst(rst), .i_trigger_bus_line(line),
    .o_trigger_bus_line(out), .o_trigger_bus_line_oe_n(oe_n), .i_star_trig(star),
    .o_star_trig(star_out), .o_star_trig_oe_n(star_oe_n), .i_axis_trig(axis),
    .i_bp_event(ev), .i_cfg_we(cfg_we), .i_cfg_is_cap(is_cap), .i_cfg_dest(dest),
    .i_cfg_src(src), .i_cap_pol(cap_pol), .i_must_on_must_off_write_we(must_on_must_off_write_we), .i_must_on(on),
    .i_must_off(off), .i_port_pol(ppol), .i_port_rd(rd), .o_port_rd_data(rd_data),
    .o_line_state(state), .o_cap_strobe(cap));

  initial
  begin
    forever #10 clk = ~clk;
  end

  task tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task cfg(input logic c, input logic [3:0] d, input logic [3:0] s);
    cfg_we = 1;
    is_cap = c;
    dest = d;
    src = s;
    tick(1);
    cfg_we = 0;
  endtask : cfg

  task must_on_must_off_write(input logic [7:0] set_bits, input logic [7:0] clr_bits);
    must_on_must_off_write_we = 1;
    on = set_bits;
    off = clr_bits;
    tick(1);
    must_on_must_off_write_we = 0;
  endtask : must_on_must_off_write

  // Counts high cycles of line and star outputs, line rising edges and capture strobes.
  task watch(input int n);
    logic [7:0] prev;
    prev = out;
    sh = 0;
    lh = '{default: 0};
    lr = '{default: 0};
    ch = '{default: 0};
    repeat (n)
    begin
      tick(1);
      sh += int'(star_out === 1'b1);
      for (int i = 0; i < 8; i++)
      begin
        lh[i] += int'(out[i] === 1'b1);
        lr[i] += int'(out[i] === 1'b1 && prev[i] === 1'b0);
        ch[i] += int'(cap[i] === 1'b1);
      end
      prev = out;
    end
  endtask : watch

  task t_reset;
    check("oe_n", oe_n, `MTSR_RST_LINE_EN ^ 8'hff);
    check("star_oe_n", {7'h00, star_oe_n}, 8'h01);
    check("out", out, 8'h00);
  endtask : t_reset

  task t_soft;
    cfg(0, 4'h2, `MTSR_LINE_SRC_SOFT);
    tick(1);
    check("oe_n", oe_n, 8'hfb);
    must_on_must_off_write(8'h04, 8'h04);
    tick(1);
    check("out2", out & 8'h04, 8'h04);
    tick(6);
    check("state2", state & 8'h04, 8'h04);
    must_on_must_off_write(8'h00, 8'h04);
    tick(1);
    check("out2", out & 8'h04, 8'h00);
    cfg(0, 4'h8, `MTSR_LINE_SRC_SOFT);
    tick(1);
    check("star_oe_n", {7'h00, star_oe_n}, 8'h00);
    check("star_out", {7'h00, star_out}, 8'h00);
  endtask : t_soft

  task t_break(input int ax, input int ln);
    cfg(0, 4'h8, 4'(ax));
    tick(1);
    cfg(0, 4'(ln), 4'(ax));
    ev[ax] = 1;
    tick(1);
    ev[ax] = 0;
    watch(14);
    check("bp_len", 8'(lh[ln]), 8'(`MTSR_PULSE_CYC));
    check("bp_rise", 8'(lr[ln]), 8'h01);
    check("bp_star", 8'(sh), 8'(`MTSR_PULSE_CYC));
  endtask : t_break

  task t_capture;
    axis[0] = 1;
    watch(10);
    check("own_trig", 8'(ch[0]), 8'h01);
    cfg(1, 4'h2, `MTSR_CAP_SRC_STAR);
    star = 1;
    watch(10);
    check("star_cap", 8'(ch[2]), 8'h01);
    cfg(0, 4'h3, `MTSR_LINE_SRC_SOFT);
    tick(1);
    check("oe_n3", oe_n & 8'h08, 8'h00);
    cfg(1, 4'h1, 4'h3);
    tick(1);
    check("oe_n3", oe_n & 8'h08, 8'h08);
    for (int k = 0; k < 4; k++)
    begin
      cap_pol[1] = (k > 1);
      drv_val[3] = !drv_val[3];
      watch(10);
      check("cap1", 8'(ch[1]), 8'(k == 1 || k == 2));
      check("state3", state & 8'h08, {4'h0, drv_val[3], 3'h0});
    end
  endtask : t_capture

  task t_read;
    rd = 1;
    tick(1);
    rd = 0;
    drv_val[6] = 1;
    tick(4);
    drv_val[6] = 0;
    tick(8);
    for (int k = 0; k < 2; k++)
    begin
      rd = 1;
      tick(1);
      rd = 0;
      tick(1);
      check("rd6", rd_data & 8'h40, k ? 8'h00 : 8'h40);
    end
  endtask : t_read

  task end_sim;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  initial
  begin
    #(3000 * 20);
    err_total++;
    end_sim();
  end

  initial
  begin
    tick(3);
    rst = 0;
    tick(1);
    t_reset();
    t_soft();
    t_break(3, 5);
    t_break(7, 0);
    t_break(0, 7);
    t_capture();
    t_read();
    end_sim();
  end
endmodule : mtsr_router_bench

`default_nettype wire
